// ### shared/fdm_pkg.sv
// Constants and types for the flash data memory controller
package fdm_pkg;
  // ------------------------------------------------------------
  // Array geometry
  // ------------------------------------------------------------
  localparam int ARR_DEPTH = 64;
  localparam int ADDR_W = 6;
  localparam int CELL_W = 12;
  localparam int BYTE_W = 8;
  localparam int LATCH_N = 4;
  localparam int ROW_WORDS = 8;
  localparam logic [3:0] UPPER_FILL = 4'hF;
  localparam logic [11:0] ERASED_CELL = 12'hFFF;
  localparam logic [1:0] LAST_LATCH = 2'h3;

  // ------------------------------------------------------------
  // Register select codes and control bit positions
  // ------------------------------------------------------------
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_DATA = 2'h1;
  localparam logic [1:0] SEL_ADDR = 2'h2;
  localparam logic [2:0] BIT_READ = 3'h0;
  localparam logic [2:0] BIT_START = 3'h1;
  localparam logic [2:0] BIT_UNLOCK = 3'h2;
  localparam logic [2:0] BIT_ABORT = 3'h3;
  localparam logic [2:0] BIT_ERASE = 3'h4;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ------------------------------------------------------------
  // Timing: array cycle lengths rounded up to clock cycles
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int ERASE_TIME_NS = 2000000;
  localparam int PROG_TIME_NS = 2000000;
  localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 20;

  // Gray order along idle, read, erase, program
  typedef enum logic [1:0] {
    FDM_IDLE = 2'h0,
    FDM_READ = 2'h1,
    FDM_ERASE = 2'h3,
    FDM_PROG = 2'h2
  } fdm_state_t;
endpackage : fdm_pkg

// ### shared/fdm_arr_if.sv
// Port bundle between the controller and the flash cell array
interface fdm_arr_if;
  logic rd_en;
  logic wr_en;
  logic [5:0] addr;
  logic [11:0] wdata;
  logic [11:0] rdata;
  modport ctrl (output rd_en, output wr_en, output addr, output wdata, input rdata);
  modport mem (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface : fdm_arr_if

// ### src/fdm_array.sv
// 64 x 12 flash cell array with registered read data
module fdm_array (
  input wire logic clock,
  fdm_arr_if.mem arr
);
  logic [fdm_pkg::CELL_W-1:0] cells [fdm_pkg::ARR_DEPTH];
  logic [fdm_pkg::CELL_W-1:0] rdata_ff;

  // Cells keep content over reset, like real flash
  always_ff @(posedge clock) begin
    if (arr.wr_en) begin
      cells[arr.addr] <= arr.wdata;
    end
    if (arr.rd_en) begin
      rdata_ff <= cells[arr.addr];
    end
  end

  assign arr.rdata = rdata_ff;
endmodule : fdm_array

// ### src/fdm_ctrl.sv
// Flash data memory controller: control, data and address registers
module fdm_ctrl #(
  parameter int ERASE_CYCLES = fdm_pkg::ERASE_CYCLES,
  parameter int PROG_CYCLES = fdm_pkg::PROG_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic por,
  input wire logic instr_step,
  input wire logic cpu_wr,
  input wire logic [1:0] cpu_sel,
  input wire logic cpu_bitset,
  input wire logic [2:0] cpu_bit,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] ctrl_q,
  output logic [7:0] data_q,
  output logic [7:0] addr_q,
  output logic stall
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  fdm_pkg::fdm_state_t state_ff, nxt_state;
  logic [fdm_pkg::CNT_W-1:0] cnt_ff;
  logic [fdm_pkg::ADDR_W-1:0] addr_ff;
  logic [fdm_pkg::BYTE_W-1:0] data_ff;
  logic [fdm_pkg::BYTE_W-1:0] latch_ff [fdm_pkg::LATCH_N];
  logic read_ff, start_ff, unlock_ff, abort_ff, erase_ff;
  logic erase_arm_ff, unlock_arm_ff, stall_ff;

  fdm_arr_if arr ();

  fdm_array u_array (
    .clock(clock),
    .arr(arr)
  );

  // ------------------------------------------------------------
  // Decode of core accesses
  // ------------------------------------------------------------
  // Accesses only count on an idle controller; the core is stalled otherwise
  wire idle = (state_ff == fdm_pkg::FDM_IDLE);
  wire busy_wr = (state_ff == fdm_pkg::FDM_ERASE) || (state_ff == fdm_pkg::FDM_PROG);
  wire acc = instr_step && cpu_wr && idle;
  wire acc_ctrl = acc && (cpu_sel == fdm_pkg::SEL_CTRL);
  wire acc_data = acc && (cpu_sel == fdm_pkg::SEL_DATA);
  wire acc_addr = acc && (cpu_sel == fdm_pkg::SEL_ADDR);
  wire bs_ctrl = acc_ctrl && cpu_bitset;
  wire plain_ctrl = acc_ctrl && !cpu_bitset;
  wire set_read = bs_ctrl && (cpu_bit == fdm_pkg::BIT_READ);
  wire set_unlock = bs_ctrl && (cpu_bit == fdm_pkg::BIT_UNLOCK);
  wire set_start = bs_ctrl && (cpu_bit == fdm_pkg::BIT_START) && unlock_arm_ff;
  wire set_erase = bs_ctrl ? (cpu_bit == fdm_pkg::BIT_ERASE)
                           : (plain_ctrl && cpu_wdata[fdm_pkg::BIT_ERASE]);
  wire set_abort = bs_ctrl && (cpu_bit == fdm_pkg::BIT_ABORT);
  wire start_erase = set_start && erase_ff;
  wire start_load = set_start && !erase_ff;
  wire last_latch = (addr_ff[1:0] == fdm_pkg::LAST_LATCH);
  wire start_prog = start_load && last_latch;
  wire erase_done = (state_ff == fdm_pkg::FDM_ERASE)
                    && (cnt_ff == fdm_pkg::CNT_W'(ERASE_CYCLES - 1));
  wire prog_done = (state_ff == fdm_pkg::FDM_PROG)
                   && (cnt_ff == fdm_pkg::CNT_W'(PROG_CYCLES - 1));
  wire cycle_done = erase_done || prog_done;

  // ------------------------------------------------------------
  // Array port drive
  // ------------------------------------------------------------
  // row from bits 5..3
  wire [5:0] erase_addr = {addr_ff[5:3], cnt_ff[2:0]};
  wire [5:0] prog_addr = {addr_ff[5:2], cnt_ff[1:0]};
  wire erase_wr = (state_ff == fdm_pkg::FDM_ERASE)
                  && (cnt_ff < fdm_pkg::CNT_W'(fdm_pkg::ROW_WORDS));
  wire prog_wr = (state_ff == fdm_pkg::FDM_PROG)
                 && (cnt_ff < fdm_pkg::CNT_W'(fdm_pkg::LATCH_N));
  assign arr.rd_en = set_read;
  assign arr.wr_en = erase_wr || prog_wr;
  assign arr.addr = erase_wr ? erase_addr : (prog_wr ? prog_addr : addr_ff);
  assign arr.wdata = erase_wr ? fdm_pkg::ERASED_CELL
                              : {fdm_pkg::UPPER_FILL, latch_ff[cnt_ff[1:0]]};

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // Next state; erase and program return to idle on their own count, read after one cycle
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      fdm_pkg::FDM_IDLE: begin
        if (set_read) begin
          nxt_state = fdm_pkg::FDM_READ;
        end else if (start_erase) begin
          nxt_state = fdm_pkg::FDM_ERASE;
        end else if (start_prog) begin
          nxt_state = fdm_pkg::FDM_PROG;
        end
      end
      fdm_pkg::FDM_READ: begin
        nxt_state = fdm_pkg::FDM_IDLE;
      end
      fdm_pkg::FDM_ERASE: begin
        if (erase_done) begin
          nxt_state = fdm_pkg::FDM_IDLE;
        end
      end
      fdm_pkg::FDM_PROG: begin
        if (prog_done) begin
          nxt_state = fdm_pkg::FDM_IDLE;
        end
      end
      default: begin
        nxt_state = fdm_pkg::FDM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff <= fdm_pkg::FDM_IDLE;
      stall_ff <= 1'b0;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      stall_ff <= (nxt_state != fdm_pkg::FDM_IDLE);
      cnt_ff <= idle ? '0 : cnt_ff + fdm_pkg::CNT_W'(1);
    end
  end

  // ------------------------------------------------------------
  // Address, data and latches
  // ------------------------------------------------------------
  // read loads data
  // data held until read or write
  always_ff @(posedge clock) begin
    if (reset) begin
      addr_ff <= '0;
      data_ff <= '0;
    end else begin
      if (acc_addr) begin
        addr_ff <= cpu_wdata[fdm_pkg::ADDR_W-1:0];
      end
      if (state_ff == fdm_pkg::FDM_READ) begin
        data_ff <= arr.rdata[fdm_pkg::BYTE_W-1:0];
      end else if (acc_data) begin
        data_ff <= cpu_wdata;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < fdm_pkg::LATCH_N; gi++) begin : g_latch
      always_ff @(posedge clock) begin
        if (reset) begin
          latch_ff[gi] <= '0;
        end else if (start_load && (addr_ff[1:0] == 2'(gi))) begin
          latch_ff[gi] <= data_ff;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Control bits
  // ------------------------------------------------------------
  // Arm flags remember what the previous instruction set
  always_ff @(posedge clock) begin
    if (reset) begin
      erase_arm_ff <= 1'b0;
      unlock_arm_ff <= 1'b0;
    end else if (instr_step) begin
      erase_arm_ff <= set_erase;
      unlock_arm_ff <= set_unlock;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      read_ff <= 1'b0;
      start_ff <= 1'b0;
    end else begin
      read_ff <= set_read;
      start_ff <= set_start || (busy_wr && !cycle_done && start_ff);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      erase_ff <= 1'b0;
    end else if (set_erase) begin
      erase_ff <= 1'b1;
    end else if (plain_ctrl) begin
      erase_ff <= 1'b0;
    end else if (erase_done) begin
      erase_ff <= 1'b0;
    end else if (instr_step && erase_arm_ff && !set_unlock && idle) begin
      erase_ff <= 1'b0;
    end
  end

  // unlock timeout
  // Unlock is spent by the start it enables, so every cycle needs a fresh one
  always_ff @(posedge clock) begin
    if (reset) begin
      unlock_ff <= 1'b0;
    end else if (set_unlock) begin
      unlock_ff <= 1'b1;
    end else if (set_start) begin
      unlock_ff <= 1'b0;
    end else if (plain_ctrl && !cpu_wdata[fdm_pkg::BIT_UNLOCK]) begin
      unlock_ff <= 1'b0;
    end else if (instr_step && unlock_arm_ff) begin
      unlock_ff <= 1'b0;
    end
  end

  // abort flag survives device reset; power-on, a finished cycle or a plain control write with bit 3 low clears it
  always_ff @(posedge clock) begin
    if (por) begin
      abort_ff <= 1'b0;
    end else if (reset) begin
      abort_ff <= abort_ff || busy_wr;
    end else if (set_abort || (plain_ctrl && cpu_wdata[fdm_pkg::BIT_ABORT])) begin
      abort_ff <= 1'b1;
    end else if (plain_ctrl || cycle_done) begin
      abort_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // control layout
  assign ctrl_q = {3'h0, erase_ff, abort_ff, unlock_ff, start_ff, read_ff};
  assign data_q = data_ff;
  assign addr_q = {2'h0, addr_ff};
  assign stall = stall_ff;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // read bit one cycle
  property p_read_clear;
    @(posedge clock) disable iff (reset) set_read |=> read_ff ##1 !read_ff;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read bit not self-cleared");

  property p_read_data;
    @(posedge clock) disable iff (reset)
      set_read |=> ##1 (data_ff == $past(arr.rdata[7:0]));
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not loaded");

  property p_stall;
    @(posedge clock) disable iff (reset) (set_read || start_erase) |=> stall;
  endproperty
  a_stall: assert property (p_stall) else $error("no stall after start");

  property p_erase_timeout;
    @(posedge clock) disable iff (reset)
      (instr_step && idle && erase_arm_ff && !set_unlock && !set_erase) |=> !erase_ff;
  endproperty
  a_erase_timeout: assert property (p_erase_timeout) else $error("erase select kept");

  property p_unlock_timeout;
    @(posedge clock) disable iff (reset)
      (instr_step && unlock_arm_ff && !set_unlock) |=> !unlock_ff;
  endproperty
  a_unlock_timeout: assert property (p_unlock_timeout) else $error("unlock kept");

  property p_unlock_bitset;
    @(posedge clock) disable iff (reset) (plain_ctrl && !unlock_ff) |=> !unlock_ff;
  endproperty
  a_unlock_bitset: assert property (p_unlock_bitset) else $error("unlock by plain write");

  property p_last_prog;
    @(posedge clock) disable iff (reset)
      start_prog |=> (state_ff == fdm_pkg::FDM_PROG) && arr.wr_en;
  endproperty
  a_last_prog: assert property (p_last_prog) else $error("program not started");

  property p_upper_fill;
    @(posedge clock) disable iff (reset) arr.wr_en |-> (arr.wdata[11:8] == 4'hF);
  endproperty
  a_upper_fill: assert property (p_upper_fill) else $error("upper nibble not set");

  property p_erase_row;
    @(posedge clock) disable iff (reset)
      erase_wr |-> (arr.addr[5:3] == addr_ff[5:3]) && (arr.wdata == 12'hFFF);
  endproperty
  a_erase_row: assert property (p_erase_row) else $error("erase outside row");

  property p_start_low;
    @(posedge clock) disable iff (reset) cycle_done |=> !start_ff && !erase_ff;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit stuck");

  property p_abort;
    @(posedge clock) disable iff (por) (reset && busy_wr) |=> abort_ff;
  endproperty
  a_abort: assert property (p_abort) else $error("abort flag not set");

  c_read: cover property (@(posedge clock) disable iff (reset) set_read);
  c_erase: cover property (@(posedge clock) disable iff (reset) erase_done);
  c_prog: cover property (@(posedge clock) disable iff (reset) prog_done);
endmodule : fdm_ctrl

// ### verification/fdm_core_model.sv
// Core model that issues register instructions to the flash controller
module fdm_core_model (
  input wire logic clock,
  input wire logic stall,
  output logic instr_step,
  output logic cpu_wr,
  output logic [1:0] cpu_sel,
  output logic cpu_bitset,
  output logic [2:0] cpu_bit,
  output logic [7:0] cpu_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // Instruction issue
  // ------------------------------------------------------------
  // Every cycle is an instruction cycle except the random empty slot that issue may insert
  initial begin
    instr_step = 1'b1;
    cpu_wr = 1'b0;
    cpu_sel = 2'h0;
    cpu_bitset = 1'b0;
    cpu_bit = 3'h0;
    cpu_wdata = 8'h00;
  end

  // instructions held one cycle
  // A stalled core fetches nothing, so the request drops first and waits out the stall
  task automatic issue(input logic bs, input logic [1:0] sel, input logic [2:0] b,
                       input logic [7:0] d);
    begin
      if (stall === 1'b1) begin
        cpu_wr = 1'b0;
        while (stall !== 1'b0) begin
          @(posedge clock);
          #1;
        end
      end
      // Random slot that is no instruction cycle; timeouts must wait for a real step
      if ($urandom_range(1) == 1) begin
        instr_step = 1'b0;
        @(posedge clock);
        #1;
        instr_step = 1'b1;
      end
      cpu_wr = 1'b1;
      cpu_sel = sel;
      cpu_bitset = bs;
      cpu_bit = b;
      cpu_wdata = d;
      @(posedge clock);
      #1;
    end
  endtask : issue

  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    issue(1'b0, sel, 3'h0, d);
  endtask : wr

  // single bit-set on the control register
  task automatic bs(input logic [2:0] b);
    issue(1'b1, fdm_pkg::SEL_CTRL, b, 8'h00);
  endtask : bs

  // One instruction cycle that touches no register
  task automatic quiet();
    cpu_wr = 1'b0;
    @(posedge clock);
    #1;
  endtask : quiet

  // non-register instructions; this core never takes interrupts
  task automatic idle(input int n);
    quiet();
    while (stall !== 1'b0) begin
      @(posedge clock);
      #1;
    end
    repeat (n) begin
      @(posedge clock);
      #1;
    end
  endtask : idle
endmodule : fdm_core_model

// ### verification/flash_data_memory_control_test.sv
// Self-checking bench for the flash data memory controller
module flash_data_memory_control_test;
  timeunit 1ns;
  timeprecision 100ps;

  // Short array cycles keep the run small
  localparam int CYC = 16;
  typedef struct packed {logic [31:0] len; logic [7:0] ctrl; logic [7:0] data;} fdm_note_t;

  logic clock, reset, por, instr_step, cpu_wr, cpu_bitset, stall;
  logic [1:0] cpu_sel;
  logic [2:0] cpu_bit;
  logic [7:0] cpu_wdata, ctrl_q, data_q, addr_q;
  int bad_count, n_checks;
  fdm_note_t notes[$];
  fdm_note_t note;
  logic [7:0] mem_img [4];
  logic [7:0] exp;
  logic [2:0] row;
  logic [31:0] run_len;

  fdm_ctrl #(.ERASE_CYCLES(CYC), .PROG_CYCLES(CYC)) u_fdm_ctrl (
    .clock(clock), .reset(reset), .por(por), .instr_step(instr_step), .cpu_wr(cpu_wr),
    .cpu_sel(cpu_sel), .cpu_bitset(cpu_bitset), .cpu_bit(cpu_bit), .cpu_wdata(cpu_wdata),
    .ctrl_q(ctrl_q), .data_q(data_q), .addr_q(addr_q), .stall(stall)
  );

  fdm_core_model u_fdm_core_model (
    .clock(clock), .stall(stall), .instr_step(instr_step), .cpu_wr(cpu_wr),
    .cpu_sel(cpu_sel), .cpu_bitset(cpu_bitset), .cpu_bit(cpu_bit), .cpu_wdata(cpu_wdata)
  );

  // ------------------------------------------------------------
  // Clock, comparison and closing
  // ------------------------------------------------------------
  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Shared comparison
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", name, want, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // Watchdog: the sequence needs well under 1000 cycles
  initial begin
    #(40 * 4000);
    bad_count++;
    $display("unexpected watchdog expiry");
    end_of_test();
  end

  // ------------------------------------------------------------
  // Result monitor
  // ------------------------------------------------------------
  // A finished stall is one result; a stall cut by reset is not
  always @(negedge clock) begin
    if (reset !== 1'b0) begin
      run_len = 0;
    end else if (stall === 1'b1) begin
      run_len = run_len + 1;
    end else if (run_len != 0) begin
      if (notes.size() == 0) begin
        check("unrequested cycle", run_len, 32'h0);
      end else begin
        note = notes.pop_front();
        check("stall length", run_len, note.len);
        check("control after cycle", ctrl_q, note.ctrl);
        check("data after cycle", data_q, note.data);
      end
      run_len = 0;
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    reset = 1'b1;
    por = 1'b1;
    run_len = 0;
    bad_count = 0;
    n_checks = 0;
    void'($urandom(38));
    repeat (5) @(posedge clock);
    #1;
    reset = 1'b0;
    por = 1'b0;
    check("ctrl reset", ctrl_q, 8'h00);
    check("data reset", data_q, 8'h00);
    check("addr reset", addr_q, 8'h00);
    // plain writes cannot set read, unlock or start
    u_fdm_core_model.wr(fdm_pkg::SEL_CTRL, 8'h07);
    u_fdm_core_model.idle(3);
    check("plain ctrl write", ctrl_q, 8'h00);
    u_fdm_core_model.wr(2'h3, 8'hA5);
    u_fdm_core_model.idle(2);
    check("unmapped data", data_q, 8'h00);
    check("unmapped addr", addr_q, 8'h00);
    u_fdm_core_model.bs(fdm_pkg::BIT_START);
    u_fdm_core_model.idle(3);
    check("start locked", ctrl_q, 8'h00);
    u_fdm_core_model.bs(fdm_pkg::BIT_ERASE);
    u_fdm_core_model.idle(3);
    check("erase timeout", ctrl_q, 8'h00);
    u_fdm_core_model.bs(fdm_pkg::BIT_UNLOCK);
    u_fdm_core_model.idle(3);
    check("unlock timeout", ctrl_q, 8'h00);
    u_fdm_core_model.wr(fdm_pkg::SEL_ADDR, 8'hFF);
    u_fdm_core_model.idle(1);
    check("addr width", addr_q, 8'h3F);
    // reset in mid-erase leaves the abort flag
    row = 3'($urandom);
    u_fdm_core_model.wr(fdm_pkg::SEL_ADDR, {2'h0, row, 3'h0});
    u_fdm_core_model.bs(fdm_pkg::BIT_ERASE);
    u_fdm_core_model.bs(fdm_pkg::BIT_UNLOCK);
    u_fdm_core_model.bs(fdm_pkg::BIT_START);
    u_fdm_core_model.quiet();
    repeat (3) @(posedge clock);
    #1;
    reset = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    reset = 1'b0;
    check("abort flag", ctrl_q, 8'h08);
    // full erase of the row clears select and abort
    u_fdm_core_model.wr(fdm_pkg::SEL_ADDR, {2'h0, row, 3'h5});
    u_fdm_core_model.bs(fdm_pkg::BIT_ERASE);
    u_fdm_core_model.bs(fdm_pkg::BIT_UNLOCK);
    notes.push_back('{CYC, 8'h00, 8'h00});
    u_fdm_core_model.bs(fdm_pkg::BIT_START);
    u_fdm_core_model.idle(2);
    // four latch loads, the last one commits
    for (int i = 0; i < 4; i++) begin
      mem_img[i] = 8'($urandom);
      u_fdm_core_model.wr(fdm_pkg::SEL_ADDR, {2'h0, row, 1'b0, 2'(i)});
      u_fdm_core_model.wr(fdm_pkg::SEL_DATA, mem_img[i]);
      u_fdm_core_model.bs(fdm_pkg::BIT_UNLOCK);
      if (i == 3) begin
        notes.push_back('{CYC, 8'h00, mem_img[i]});
      end
      u_fdm_core_model.bs(fdm_pkg::BIT_START);
    end
    // reads of the whole row, each after its own address write
    for (int i = 0; i < 8; i++) begin
      exp = (i < 4) ? mem_img[i] : 8'hFF;
      u_fdm_core_model.wr(fdm_pkg::SEL_ADDR, {2'h0, row, 3'(i)});
      notes.push_back('{32'h1, 8'h00, exp});
      u_fdm_core_model.bs(fdm_pkg::BIT_READ);
    end
    u_fdm_core_model.idle(4);
    check("data hold", data_q, exp);
    // a device reset that cuts an erase sets abort and power-on reset clears it
    u_fdm_core_model.bs(fdm_pkg::BIT_ERASE);
    u_fdm_core_model.bs(fdm_pkg::BIT_UNLOCK);
    u_fdm_core_model.bs(fdm_pkg::BIT_START);
    u_fdm_core_model.quiet();
    reset = 1'b1;
    @(posedge clock);
    #1;
    check("abort on cut", ctrl_q, 8'h08);
    por = 1'b1;
    @(posedge clock);
    #1;
    reset = 1'b0;
    por = 1'b0;
    check("abort after power-on", ctrl_q, 8'h00);
    check("results pending", notes.size(), 32'h0);
    end_of_test();
  end
endmodule : flash_data_memory_control_test
